//--- design/srm_map.vh
// Bit positions, reset values and strobe layout of the status reporting block
`ifndef SRM_MAP_VH
`define SRM_MAP_VH
// Standard event latch bit positions
`define SRM_EV_OPC 0
`define SRM_EV_CRQ 1
`define SRM_EV_QYE 2
`define SRM_EV_DDE 3
`define SRM_EV_EXE 4
`define SRM_EV_CME 5
`define SRM_EV_URQ 6
`define SRM_EV_PON 7
// Summary status byte bit positions
`define SRM_SB_MAV 4
`define SRM_SB_ESB 5
`define SRM_SB_MSS 6
`define SRM_SB_OSE 7
// Power-on value of the event latch: only the power-on flag set
`define SRM_EVL_RESET 8'h80
// Bits that can never be set: user request and control request
`define SRM_EVL_NEVER 8'h42
// Service request mask bit ignored when forming the master summary
`define SRM_SRM_IGNORE 8'h40
`define SRM_MASK_RESET 8'h00
// Error-class codes on the queue push strobe
`define SRM_ERR_NONE 2'h0
`define SRM_ERR_CMD 2'h0
`define SRM_ERR_RUN 2'h1
`define SRM_ERR_DEV 2'h2
`define SRM_ERR_QRY 2'h3
`endif

//--- design/srm_err_push.v
// Error-queue push strobe and class encoder for the status reporting block
`include "srm_map.vh"

module srm_err_push (
   input wire mclk_in,
   input wire rst_n_in,
   input wire cmd_err_in,
   input wire run_fail_in,
   input wire dev_err_in,
   input wire qry_err_in,
   output reg push_out,
   output reg [1:0] class_out
);
   // ************************************************
   // Push register
   // ************************************************
   // One push per cycle; when several errors coincide the command error wins
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         push_out <= 1'b0;
         class_out <= `SRM_ERR_NONE;
      end else begin
         push_out <= cmd_err_in | run_fail_in | dev_err_in | qry_err_in;
         if (cmd_err_in) begin
            class_out <= `SRM_ERR_CMD;
         end else if (run_fail_in) begin
            class_out <= `SRM_ERR_RUN;
         end else if (dev_err_in) begin
            class_out <= `SRM_ERR_DEV;
         end else if (qry_err_in) begin
            class_out <= `SRM_ERR_QRY;
         end else begin
            class_out <= `SRM_ERR_NONE;
         end
      end
   end
endmodule

//--- design/srm_status_model.v
// Status reporting model: event latch, enable masks, status byte and service request
//
// Overview of operation
// - Power-up sets power-on flag, bit 7
// - User and control request flags stay zero
// - Command error sets bit 5, queues error
// - Run failure sets bit 4, queues error
// - Device error sets bit 3, queues error
// - Query error sets bit 2, queues error
// - Completion command sets bit 0
// - Flags latch; latch read returns, then clears
// - Flags hold until latch read or clear
// - Event summary is OR of masked latch
// - Status byte follows conditions, read never clears
// - Bit 7 shows any operation event set
// - Master summary ORs masked status bits
// - Bit 4 shows reply buffer not empty
// - Status bits 3 to 0 read zero
// - Master summary rise raises service request
// - Mask bit 6 ignored for master summary
// - Power-on latch value is only bit 7
// - Clear command zeroes latch and both masks
`include "srm_map.vh"

module srm_status_model (
   input wire mclk_in,
   input wire rst_n_in,
   input wire cmd_err_in,
   input wire run_fail_in,
   input wire dev_err_in,
   input wire qry_err_in,
   input wire opc_exec_in,
   input wire cls_in,
   input wire latch_rd_in,
   input wire event_mask_wr_in,
   input wire service_mask_wr_in,
   input wire [7:0] mask_wdata_in,
   input wire op_event_any_in,
   input wire reply_pending_in,
   output reg [7:0] standard_event_latch_out,
   output reg [7:0] latch_rdata_out,
   output reg [7:0] summary_status_byte_out,
   output reg [7:0] event_enable_mask_out,
   output reg [7:0] service_request_mask_out,
   output reg srq_out,
   output reg err_push_out,
   output reg [1:0] err_class_out
);
   // ************************************************
   // Declarations
   // ************************************************
   reg [7:0] next_latch;
   reg [7:0] set_bits;
   reg [7:0] next_status;
   reg [7:0] status_base;
   reg op_meta;
   reg op_sync;
   reg reply_meta;
   reg reply_sync;
   wire push_w;
   wire [1:0] class_w;

   // ************************************************
   // Pin synchronisers
   // ************************************************
   // Operation event and reply-pending come from outside logic, so two flops each
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         op_meta <= 1'b0;
         op_sync <= 1'b0;
         reply_meta <= 1'b0;
         reply_sync <= 1'b0;
      end else begin
         op_meta <= op_event_any_in;
         op_sync <= op_meta;
         reply_meta <= reply_pending_in;
         reply_sync <= reply_meta;
      end
   end

   // ************************************************
   // Event latch
   // ************************************************
   // Events arriving with a read or clear are kept: set wins over clear
   always @* begin
      set_bits = 8'h00;
      set_bits[`SRM_EV_CME] = cmd_err_in;
      set_bits[`SRM_EV_EXE] = run_fail_in;
      set_bits[`SRM_EV_DDE] = dev_err_in;
      set_bits[`SRM_EV_QYE] = qry_err_in;
      set_bits[`SRM_EV_OPC] = opc_exec_in;
      if (latch_rd_in || cls_in) begin
         next_latch = set_bits;
      end else begin
         next_latch = standard_event_latch_out | set_bits;
      end
      next_latch = next_latch & ~`SRM_EVL_NEVER;
   end

   // Latch register; reset stands for power-up
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         standard_event_latch_out <= `SRM_EVL_RESET;
      end else begin
         standard_event_latch_out <= next_latch;
      end
   end

   // Read data holds the value as it stood when the read was taken
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         latch_rdata_out <= 8'h00;
      end else if (latch_rd_in) begin
         latch_rdata_out <= standard_event_latch_out;
      end
   end

   // ************************************************
   // Mask registers
   // ************************************************
   // Clear wins over a write in the same cycle
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         event_enable_mask_out <= `SRM_MASK_RESET;
         service_request_mask_out <= `SRM_MASK_RESET;
      end else if (cls_in) begin
         event_enable_mask_out <= `SRM_MASK_RESET;
         service_request_mask_out <= `SRM_MASK_RESET;
      end else begin
         if (event_mask_wr_in) begin
            event_enable_mask_out <= mask_wdata_in;
         end
         if (service_mask_wr_in) begin
            service_request_mask_out <= mask_wdata_in;
         end
      end
   end

   // ************************************************
   // Status byte
   // ************************************************
   // Built from the next latch value so the byte tracks the latch with no extra lag.
   // The summary inputs are gathered in a separate vector first, so the master
   // summary never reads the vector it is written into (no feedback in the process).
   always @* begin
      status_base = 8'h00;
      status_base[`SRM_SB_OSE] = op_sync;
      status_base[`SRM_SB_MAV] = reply_sync;
      status_base[`SRM_SB_ESB] = |(next_latch & event_enable_mask_out);
      next_status = status_base;
      // Mask bit 6 is stored for read-back but can never enable the summary itself
      next_status[`SRM_SB_MSS] = |(status_base & service_request_mask_out & ~`SRM_SRM_IGNORE);
   end

   // Live status: reading never touches it
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         summary_status_byte_out <= 8'h00;
      end else begin
         summary_status_byte_out <= next_status;
      end
   end

   // ************************************************
   // Service request
   // ************************************************
   // One-cycle pulse on the rising master summary; level stays in the byte
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         srq_out <= 1'b0;
      end else begin
         srq_out <= next_status[`SRM_SB_MSS] & ~summary_status_byte_out[`SRM_SB_MSS];
      end
   end

   // ************************************************
   // Error queue push
   // ************************************************
   srm_err_push u_push (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .cmd_err_in(cmd_err_in),
      .run_fail_in(run_fail_in),
      .dev_err_in(dev_err_in),
      .qry_err_in(qry_err_in),
      .push_out(push_w),
      .class_out(class_w)
   );

   // Registered again so every top output comes from a flop of this module
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         err_push_out <= 1'b0;
         err_class_out <= `SRM_ERR_NONE;
      end else begin
         err_push_out <= push_w;
         err_class_out <= class_w;
      end
   end
endmodule

//--- testbench/srm_status_model_sva.sv
// Concurrent checks of the status reporting block, bound to its top module
module srm_status_sva (
   input logic mclk_in, rst_n_in, cmd_err_in, cls_in, latch_rd_in, srq_out, err_push_out,
   input logic [1:0] err_class_out,
   input logic [7:0] standard_event_latch_out, latch_rdata_out, summary_status_byte_out,
   input logic [7:0] event_enable_mask_out, service_request_mask_out
);
   // ************
   // Properties
   // ************
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // Masks land a cycle before the byte, so summaries are judged only while a mask is steady
   wire [7:0] evl = standard_event_latch_out;
   wire [7:0] sb = summary_status_byte_out;
   wire [7:0] em = event_enable_mask_out;
   wire [7:0] sm = service_request_mask_out;
   property p_never; (evl & 8'h42) == 8'h00; endproperty
   a_never: assert property (p_never) else $error("never-set flag seen");
   property p_cmd; cmd_err_in |=> evl[5]; endproperty
   a_cmd: assert property (p_cmd) else $error("command error not latched");
   property p_push; cmd_err_in |-> ##2 err_push_out && err_class_out == 2'h0; endproperty
   a_push: assert property (p_push) else $error("no error push");
   property p_read; latch_rd_in |=> latch_rdata_out == $past(evl); endproperty
   a_read: assert property (p_read) else $error("latch read value wrong");
   property p_esb; $stable(em) |-> sb[5] == |(evl & em); endproperty
   a_esb: assert property (p_esb) else $error("event summary wrong");
   property p_srq; srq_out == $rose(sb[6]); endproperty
   a_srq: assert property (p_srq) else $error("service request wrong");
   property p_mss; $stable(sm) |-> sb[6] == |(sb & sm & 8'hbf); endproperty
   a_mss: assert property (p_mss) else $error("master summary wrong");
   property p_cls; cls_in |=> em == 8'h00 && sm == 8'h00; endproperty
   a_cls: assert property (p_cls) else $error("clear left a mask");
endmodule
bind srm_status_model srm_status_sva u_sva (.*);

//--- testbench/srm_host.sv
// Host-side model issuing latch reads, mask writes and clear commands
module srm_host (
   input logic clk_in,
   output logic [3:0] req_out,
   output logic [7:0] wd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial req_out = 4'h0;
   initial wd_out = 8'h00;
   // One request: 0 latch read, 1 event mask, 2 service mask, 3 clear
   task automatic pulse(input int k, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      wd_out = d;
      req_out = 4'h1 << k;
      @(posedge clk_in);
      #1;
      req_out = 4'h0;
      wd_out = ~d; // Released data shows no stale value
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench of the status reporting block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in, rst_n_in, op, rp, srq, push;
   logic [4:0] ev;
   logic [3:0] rq;
   logic [1:0] code;
   logic [7:0] wd, evl, rdat, sb, em, sm;
   int mismatches, checked;
   srm_status_model dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_err_in(ev[4]), .run_fail_in(ev[3]),
      .dev_err_in(ev[2]), .qry_err_in(ev[1]), .opc_exec_in(ev[0]), .cls_in(rq[3]), .latch_rd_in(rq[0]),
      .event_mask_wr_in(rq[1]), .service_mask_wr_in(rq[2]), .mask_wdata_in(wd), .op_event_any_in(op),
      .reply_pending_in(rp), .standard_event_latch_out(evl), .latch_rdata_out(rdat),
      .summary_status_byte_out(sb), .event_enable_mask_out(em), .service_request_mask_out(sm),
      .srq_out(srq), .err_push_out(push), .err_class_out(code));
   srm_host host (.clk_in(mclk_in), .req_out(rq), .wd_out(wd));
   // ************
   // Helpers
   // ************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Outputs are sampled just past the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Power-up latch value, then a read that returns and clears it
   task automatic t_power;
      chk(evl, 8'h80);
      chk(sb, 8'h00);
      host.pulse(0, 8'h00);
      chk(rdat, 8'h80);
      chk(evl, 8'h00);
      $display("power test done");
   endtask
   // Each error kind in turn, then all at once to see the push priority
   task automatic t_events;
      logic [7:0] wt[5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};
      logic [1:0] cl[5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
      logic [7:0] acc = 8'h00;
      for (int k = 0; k < 5; k++) begin
         ev = 5'h01 << k;
         tick(1);
         ev = 5'h00;
         acc = acc | wt[k];
         chk(evl, acc);
         tick(1);
         chk({5'h00, push, code}, {5'h00, k != 0, cl[k]});
      end
      tick(20);
      chk(evl, 8'h3d);
      ev = 5'h1f;
      tick(1);
      ev = 5'h00;
      tick(1);
      chk({5'h00, push, code}, 8'h04);
      host.pulse(0, 8'h00);
      chk(rdat, 8'h3d);
      $display("event test done");
   endtask
   // Summary bits, service request pulse, ignored mask bit and clear
   task automatic t_summary;
      host.pulse(1, 8'h04);
      host.pulse(2, 8'h20);
      tick(1);
      ev = 5'h02;
      tick(1);
      ev = 5'h00;
      chk({srq, sb[6:0]}, 8'he0);
      tick(1);
      chk({srq, sb[6:0]}, 8'h60);
      host.pulse(2, 8'h40);
      tick(1);
      chk(sb, 8'h20);
      host.pulse(3, 8'h00);
      chk(evl | em | sm, 8'h00);
      tick(1);
      chk(sb, 8'h00);
      $display("summary test done");
   endtask
   // Level conditions follow the byte both ways and survive being looked at
   task automatic t_levels;
      host.pulse(2, 8'h90);
      op = 1'b1;
      rp = 1'b1;
      tick(3);
      chk(sb, 8'hd0);
      chk({7'h00, srq}, 8'h01);
      tick(5);
      chk(sb, 8'hd0);
      op = 1'b0;
      tick(3);
      chk(sb, 8'h50);
      rp = 1'b0;
      tick(3);
      chk(sb, 8'h00);
      $display("level test done");
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // Watchdog: the tests need about 70 cycles
   initial begin
      #20us;
      mismatches++;
      tally_and_finish;
   end
   initial begin
      ev = 5'h00;
      op = 1'b0;
      rp = 1'b0;
      rst_n_in = 1'b0;
      repeat (3) @(posedge mclk_in);
      #1;
      rst_n_in = 1'b1;
      t_power;
      t_events;
      t_summary;
      t_levels;
      tally_and_finish;
   end
endmodule
